// ### jdsc_defs.svh
// constants for the test-port and debug control block
// assumes inclusion by bare name from the package and the design file
`ifndef JDSC_DEFS_SVH
`define JDSC_DEFS_SVH
`define JDSC_IR_W        4
`define JDSC_IR_EXTEST   4'h0
`define JDSC_IR_IDCODE   4'h1
`define JDSC_IR_SAMPLE   4'h2
`define JDSC_IR_DBG_A    4'h8
`define JDSC_IR_DBG_B    4'h9
`define JDSC_IR_DBG_C    4'ha
`define JDSC_IR_DBG_D    4'hb
`define JDSC_IR_SCANRST  4'hc
`define JDSC_IR_BYPASS   4'hf
`define JDSC_IR_CAPTURE  4'h1
// identification word: arbitrary value, bit 0 set as every such word needs
`define JDSC_ID_CODE     32'h1000_0001
`define JDSC_BSR_W       8
`define JDSC_DCB_W       8
`define JDSC_CORE_DR_W   16
`define JDSC_BP_W        16
`define JDSC_BPCFG_W     3
`define JDSC_BPCFG_4P    3'h0
`define JDSC_BPCFG_3P1D  3'h1
`define JDSC_BPCFG_2P2D  3'h2
`define JDSC_BPCFG_RNGP  3'h3
`define JDSC_BPCFG_RNGD  3'h4
`endif

// ### jdsc_pkg.sv
// types for the test-port and debug control block
// assumes the constants header sits in the same folder
`include "jdsc_defs.svh"
package jdsc_pkg;
  // tap controller states, gray-coded along the scan paths
  typedef enum logic [3:0] {
    TLR  = 4'h0, RTI  = 4'h1, SDRS = 4'h3, CDR = 4'h2,
    SDR  = 4'h6, E1DR = 4'h7, PDR  = 4'h5, E2DR = 4'h4,
    UDR  = 4'hc, SIRS = 4'hd, CIR  = 4'hf, SIR = 4'he,
    E1IR = 4'ha, PIR  = 4'hb, E2IR = 4'h9, UIR = 4'h8
  } jdsc_tap_e;
  // one breakpoint comparator setting
  typedef struct packed {
    logic                  on_data;  // compare data address, not program
    logic                  masked;   // address acts as mask for a range
    logic [`JDSC_BP_W-1:0] addr;     // compare value
  } jdsc_bp_s;
  // decoded instruction selects
  typedef struct packed {
    logic extest;
    logic idcode;
    logic sample;
    logic dbg;
    logic scanrst;
    logic bypass;
  } jdsc_dec_s;
endpackage : jdsc_pkg

// ### jdsc_top.sv
// test-port control, debug enables, breakpoint unit and debug channel byte
// assumes the tap pins come from outside and are sampled on SYS_CLK;
// tck runs far slower than SYS_CLK so edges are found by sampling.
`timescale 1ns/1ps
`default_nettype none
`include "jdsc_defs.svh"
module jdsc_top (
  input  wire logic                    SYS_CLK,
  input  wire logic                    SYS_RST,
  input  wire logic                    TCK,
  input  wire logic                    TMS,
  input  wire logic                    TDI,
  output logic                         TDO,
  output logic                         TDO_OE,
  input  wire logic                    RESET_PIN_N,
  input  wire logic                    PORT_ENABLE_FUSE,
  input  wire logic                    DEBUG_ENABLE_FUSE,
  input  wire logic                    LOCK_BIT_ONE,
  input  wire logic                    LOCK_BIT_TWO,
  input  wire logic                    PORT_DISABLE_BIT,
  input  wire logic                    CHIP_ERASE_DONE,
  input  wire logic                    DEBUG_FUSE_PROG_REQ,
  input  wire logic [`JDSC_BSR_W-1:0]  PIN_IN,
  input  wire logic [`JDSC_BSR_W-1:0]  CORE_PIN_OUT,
  input  wire logic [`JDSC_BSR_W-1:0]  CORE_PIN_OE,
  output logic [`JDSC_BSR_W-1:0]       PIN_OUT,
  output logic [`JDSC_BSR_W-1:0]       PIN_OE,
  input  wire logic                    CORE_WR,
  input  wire logic                    CORE_RD,
  input  wire logic [`JDSC_DCB_W-1:0]  CORE_WDATA,
  output logic [`JDSC_DCB_W-1:0]       CORE_RDATA,
  output logic                         CORE_RESULT_VALID,
  input  wire logic [`JDSC_DCB_W-1:0]  SHARED_IO_RDATA,
  output logic                         SHARED_IO_WR,
  input  wire logic                    CORE_PC_CHANGE,
  input  wire logic                    CORE_STEP_DONE,
  input  wire logic [`JDSC_BP_W-1:0]   CORE_PC,
  input  wire logic [`JDSC_BP_W-1:0]   CORE_DADDR,
  input  wire logic                    CORE_DVALID,
  output logic                         CORE_BREAK,
  output logic [`JDSC_CORE_DR_W-1:0]   CORE_INJECT,
  output logic                         CORE_INJECT_STB,
  output logic                         DEBUG_ACTIVE,
  output logic                         DEBUG_FUSE_PROG_OK,
  output logic                         DEVICE_RESET
);

  // two-stage synchronisers for all off-domain pins; stage one read only by stage two
  logic [3:0]              sync1_reg;
  logic [3:0]              sync2_reg;
  logic                    tck_old_reg;  // previous synced tck for edge finding
  logic [`JDSC_BSR_W-1:0]  pin_s1_reg;   // pin levels, first stage
  logic [`JDSC_BSR_W-1:0]  pin_s2_reg;   // pin levels, safe to capture
  always_ff @(posedge SYS_CLK) begin
    sync1_reg   <= {RESET_PIN_N, TCK, TMS, TDI};
    sync2_reg   <= sync1_reg;
    tck_old_reg <= sync2_reg[2];
    pin_s1_reg  <= PIN_IN;
    pin_s2_reg  <= pin_s1_reg;
  end
  wire rst_pin_n = sync2_reg[3];
  wire tck_s     = sync2_reg[2];
  wire tms_s     = sync2_reg[1];
  wire tdi_s     = sync2_reg[0];
  // scan state advances only on tck edges, except that a disabled port forces the controller to reset on SYS_CLK at once
  wire tck_rise  = tck_s & ~tck_old_reg;
  wire tck_fall  = ~tck_s & tck_old_reg;

  // enables
  wire port_en = PORT_ENABLE_FUSE & ~PORT_DISABLE_BIT;
  wire locked  = LOCK_BIT_ONE | LOCK_BIT_TWO;
  wire dbg_en  = port_en & DEBUG_ENABLE_FUSE & ~locked;

  // debug fuse programming refused while locked and no erase seen since
  logic erased_reg;  // chip erase completed since locks went on
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) erased_reg <= 1'b0;
    else if (CHIP_ERASE_DONE) erased_reg <= 1'b1;
    else if (!locked) erased_reg <= 1'b0;
  end
  wire fuse_ok = DEBUG_FUSE_PROG_REQ & (~locked | erased_reg | CHIP_ERASE_DONE);

  // tap next-state table, held apart from the register update
  function automatic jdsc_pkg::jdsc_tap_e tap_next(input jdsc_pkg::jdsc_tap_e s,
                                                    input logic m);
    case (s)
      jdsc_pkg::TLR:  tap_next = m ? jdsc_pkg::TLR  : jdsc_pkg::RTI;
      jdsc_pkg::RTI:  tap_next = m ? jdsc_pkg::SDRS : jdsc_pkg::RTI;
      jdsc_pkg::SDRS: tap_next = m ? jdsc_pkg::SIRS : jdsc_pkg::CDR;
      jdsc_pkg::CDR:  tap_next = m ? jdsc_pkg::E1DR : jdsc_pkg::SDR;
      jdsc_pkg::SDR:  tap_next = m ? jdsc_pkg::E1DR : jdsc_pkg::SDR;
      jdsc_pkg::E1DR: tap_next = m ? jdsc_pkg::UDR  : jdsc_pkg::PDR;
      jdsc_pkg::PDR:  tap_next = m ? jdsc_pkg::E2DR : jdsc_pkg::PDR;
      jdsc_pkg::E2DR: tap_next = m ? jdsc_pkg::UDR  : jdsc_pkg::SDR;
      jdsc_pkg::UDR:  tap_next = m ? jdsc_pkg::SDRS : jdsc_pkg::RTI;
      jdsc_pkg::SIRS: tap_next = m ? jdsc_pkg::TLR  : jdsc_pkg::CIR;
      jdsc_pkg::CIR:  tap_next = m ? jdsc_pkg::E1IR : jdsc_pkg::SIR;
      jdsc_pkg::SIR:  tap_next = m ? jdsc_pkg::E1IR : jdsc_pkg::SIR;
      jdsc_pkg::E1IR: tap_next = m ? jdsc_pkg::UIR  : jdsc_pkg::PIR;
      jdsc_pkg::PIR:  tap_next = m ? jdsc_pkg::E2IR : jdsc_pkg::PIR;
      jdsc_pkg::E2IR: tap_next = m ? jdsc_pkg::UIR  : jdsc_pkg::SIR;
      jdsc_pkg::UIR:  tap_next = m ? jdsc_pkg::SDRS : jdsc_pkg::RTI;
      default:        tap_next = jdsc_pkg::TLR;
    endcase
  endfunction : tap_next

  // sixteen-state controller on tms at tck rise; held in reset while port off
  jdsc_pkg::jdsc_tap_e tap_reg;
  wire jdsc_pkg::jdsc_tap_e tap_next_w = tap_next(tap_reg, tms_s);
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !port_en) tap_reg <= jdsc_pkg::TLR;
    else if (tck_rise) tap_reg <= tap_next_w;
  end

  // instruction register: shift lsb first, default identification
  logic [`JDSC_IR_W-1:0] ir_sh_reg;
  logic [`JDSC_IR_W-1:0] ir_reg;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || tap_reg == jdsc_pkg::TLR) begin
      ir_reg    <= `JDSC_IR_IDCODE;
      ir_sh_reg <= `JDSC_IR_CAPTURE;
    end else if (tck_rise) begin
      if (tap_reg == jdsc_pkg::CIR) ir_sh_reg <= `JDSC_IR_CAPTURE;
      else if (tap_reg == jdsc_pkg::SIR) ir_sh_reg <= {tdi_s, ir_sh_reg[`JDSC_IR_W-1:1]};
      else if (tap_reg == jdsc_pkg::UIR) ir_reg <= ir_sh_reg;
    end
  end

  // instruction decode; debug codes only act with debug enabled
  wire jdsc_pkg::jdsc_dec_s dec;
  assign dec.extest  = ir_reg == `JDSC_IR_EXTEST;
  assign dec.idcode  = ir_reg == `JDSC_IR_IDCODE;
  assign dec.sample  = ir_reg == `JDSC_IR_SAMPLE;
  assign dec.dbg     = ir_reg[3:2] == 2'b10 && dbg_en;
  assign dec.scanrst = ir_reg == `JDSC_IR_SCANRST;
  // unknown codes fall back to the one-bit path
  assign dec.bypass  = ~(dec.extest | dec.idcode | dec.sample | dec.dbg | dec.scanrst);
  wire [1:0] dbg_op  = ir_reg[1:0];  // a: inject, b: channel read, c: bp load, d: grant

  // data registers
  logic                        byp_reg;
  logic                        rst_dr_reg;
  logic [31:0]                 id_reg;
  logic [`JDSC_BSR_W-1:0]      bsr_sh_reg;
  logic [`JDSC_BSR_W-1:0]      bsr_lat_reg;
  logic [`JDSC_CORE_DR_W-1:0]  dbg_sh_reg;
  wire capt = tck_rise && tap_reg == jdsc_pkg::CDR;
  wire shft = tck_rise && tap_reg == jdsc_pkg::SDR;
  wire updt = tck_rise && tap_reg == jdsc_pkg::UDR;

  // bypass and identification, one-bit and 32-bit scan paths
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      byp_reg <= 1'b0;
      id_reg  <= 32'h0;
    end else begin
      if (capt) byp_reg <= 1'b0;
      else if (shft) byp_reg <= tdi_s;
      if (capt) id_reg <= `JDSC_ID_CODE;
      else if (shft) id_reg <= {tdi_s, id_reg[31:1]};
    end
  end

  // reset bit: its value drives reset directly, no update latch
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || tap_reg == jdsc_pkg::TLR) rst_dr_reg <= 1'b0;
    else if (shft && dec.scanrst) rst_dr_reg <= tdi_s;
  end

  // boundary chain: capture pins, shift, update output latches
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      bsr_sh_reg  <= '0;
      bsr_lat_reg <= '0;
    end else if (dec.extest || dec.sample) begin
      if (capt) bsr_sh_reg <= pin_s2_reg;
      else if (shft) bsr_sh_reg <= {tdi_s, bsr_sh_reg[`JDSC_BSR_W-1:1]};
      else if (updt) bsr_lat_reg <= bsr_sh_reg;  // preload path too
    end
  end

  // debug scan path: injected core words, channel readout, breakpoint loads
  logic                    dirty_reg;
  logic [`JDSC_DCB_W-1:0]  dcb_reg;
  logic                    grant_reg;   // debugger granted channel access
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) dbg_sh_reg <= '0;
    else if (dec.dbg && capt)
      dbg_sh_reg <= {{(`JDSC_CORE_DR_W-`JDSC_DCB_W){1'b0}}, dcb_reg};
    else if (dec.dbg && shft) dbg_sh_reg <= {tdi_s, dbg_sh_reg[`JDSC_CORE_DR_W-1:1]};
  end

  // breakpoint resources: layout selector plus four comparators
  logic [`JDSC_BPCFG_W-1:0] bp_cfg_reg;
  jdsc_pkg::jdsc_bp_s       bp_reg [4];
  logic [1:0]               bp_idx_reg;  // next resource to load
  wire bp_load = updt && dec.dbg && dbg_op == 2'h2;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      bp_cfg_reg <= `JDSC_BPCFG_4P;
      bp_idx_reg <= 2'h0;
    end else if (bp_load) begin
      if (dbg_sh_reg[15]) bp_cfg_reg <= dbg_sh_reg[`JDSC_BPCFG_W-1:0];
      else bp_idx_reg <= bp_idx_reg + 2'h1;
    end
  end
  // each comparator kind follows the chosen layout
  function automatic jdsc_pkg::jdsc_bp_s bp_kind(input logic [2:0] cfg, input int i,
                                                 input logic [`JDSC_BP_W-1:0] a);
    bp_kind.addr    = a;
    bp_kind.on_data = (cfg == `JDSC_BPCFG_3P1D && i == 3) ||
                      (cfg == `JDSC_BPCFG_2P2D && i >= 2) ||
                      (cfg == `JDSC_BPCFG_RNGD && i >= 2);
    bp_kind.masked  = (cfg == `JDSC_BPCFG_RNGP || cfg == `JDSC_BPCFG_RNGD) && i == 3;
  endfunction : bp_kind
  logic [3:0] bp_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bp
      always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) bp_reg[gi] <= '0;
        else if (bp_load && !dbg_sh_reg[15] && bp_idx_reg == 2'(gi))
          bp_reg[gi] <= bp_kind(bp_cfg_reg, gi, {1'b0, dbg_sh_reg[14:0]});
      end
    end
  endgenerate
  // range layouts: slot 2 is base, slot 3 is mask; slot 2 then no single match
  wire rng = bp_reg[3].masked;
  wire [`JDSC_BP_W-1:0] rng_a = bp_reg[3].on_data ? CORE_DADDR : CORE_PC;
  assign bp_hit[0] = CORE_PC == bp_reg[0].addr;
  assign bp_hit[1] = CORE_PC == bp_reg[1].addr;
  assign bp_hit[2] = !rng && (bp_reg[2].on_data ? CORE_DVALID && CORE_DADDR == bp_reg[2].addr
                                                : CORE_PC == bp_reg[2].addr);
  assign bp_hit[3] = rng ? ((rng_a & bp_reg[3].addr) == (bp_reg[2].addr & bp_reg[3].addr)) &&
                           (!bp_reg[3].on_data || CORE_DVALID)
                         : (bp_reg[3].on_data ? CORE_DVALID && CORE_DADDR == bp_reg[3].addr
                                              : CORE_PC == bp_reg[3].addr);
  logic [1:0] brk_mode_reg;  // bit0 flow change, bit1 single step
  wire brk_now = dbg_en && ((|bp_hit) || (brk_mode_reg[0] && CORE_PC_CHANGE) ||
                            (brk_mode_reg[1] && CORE_STEP_DONE));

  // channel byte, dirty flag and grant
  wire chan_sel = DEBUG_ENABLE_FUSE & grant_reg;
  wire dbg_rd   = updt && dec.dbg && dbg_op == 2'h1;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      dcb_reg      <= '0;
      dirty_reg    <= 1'b0;
      grant_reg    <= 1'b0;
      brk_mode_reg <= 2'h0;
    end else begin
      if (CORE_WR && chan_sel) dcb_reg <= CORE_WDATA;
      // core write wins over a debugger clear in the same cycle
      if (CORE_WR && chan_sel) dirty_reg <= 1'b1;
      else if (dbg_rd) dirty_reg <= 1'b0;
      if (updt && dec.dbg && dbg_op == 2'h3) begin
        grant_reg    <= dbg_sh_reg[0];
        brk_mode_reg <= dbg_sh_reg[2:1];
      end
    end
  end

  // reset source and output registers
  wire dev_rst = ~rst_pin_n | (dec.scanrst & rst_dr_reg);
  wire ext_drv = dec.extest & port_en;
  wire sel_tdo = dec.bypass ? byp_reg : dec.idcode ? id_reg[0] : dec.scanrst ? rst_dr_reg :
                 dec.dbg ? dbg_sh_reg[0] : bsr_sh_reg[0];
  wire shifting = tap_reg == jdsc_pkg::SDR || tap_reg == jdsc_pkg::SIR;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      TDO <= 1'b0;
      TDO_OE <= 1'b0;
      PIN_OUT <= '0;
      PIN_OE <= '0;
      CORE_RDATA <= '0;
      CORE_RESULT_VALID <= 1'b0;
      SHARED_IO_WR <= 1'b0;
      CORE_BREAK <= 1'b0;
      CORE_INJECT <= '0;
      CORE_INJECT_STB <= 1'b0;
      DEBUG_ACTIVE <= 1'b0;
      DEBUG_FUSE_PROG_OK <= 1'b0;
      DEVICE_RESET <= 1'b1;
    end else begin
      // tdo changes on tck fall, sampled by the controller on rise
      if (tck_fall) begin
        TDO    <= tap_reg == jdsc_pkg::SIR ? ir_sh_reg[0] : sel_tdo;
        TDO_OE <= shifting & port_en;
      end else if (!port_en) TDO_OE <= 1'b0;  // a disabled port lets go at once
      // latches reach the pins as soon as external test is current
      PIN_OUT <= ext_drv ? bsr_lat_reg : CORE_PIN_OUT;
      PIN_OE  <= ext_drv ? {`JDSC_BSR_W{1'b1}} : (dev_rst ? '0 : CORE_PIN_OE);
      CORE_RDATA <= chan_sel ? {dirty_reg, dcb_reg[6:0]} : SHARED_IO_RDATA;
      CORE_RESULT_VALID <= CORE_RD;
      SHARED_IO_WR <= CORE_WR & ~chan_sel;
      CORE_BREAK <= brk_now;
      CORE_INJECT <= dbg_sh_reg;
      CORE_INJECT_STB <= updt && dec.dbg && dbg_op == 2'h0;
      DEBUG_ACTIVE <= dbg_en;
      DEBUG_FUSE_PROG_OK <= fuse_ok;
      DEVICE_RESET <= dev_rst;
    end
  end

endmodule : jdsc_top
`default_nettype wire

// ### jdsc_assertions.sv
// checker of the test-port block, seeing only its top-level ports
// assumes a bind onto jdsc_top and one system clock domain
`timescale 1ns/1ps
`default_nettype none
`include "jdsc_defs.svh"
module jdsc_assertions (
  input wire logic                   SYS_CLK,
  input wire logic                   SYS_RST,
  input wire logic                   RESET_PIN_N,
  input wire logic                   PORT_ENABLE_FUSE,
  input wire logic                   DEBUG_ENABLE_FUSE,
  input wire logic                   LOCK_BIT_ONE,
  input wire logic                   LOCK_BIT_TWO,
  input wire logic                   PORT_DISABLE_BIT,
  input wire logic                   CHIP_ERASE_DONE,
  input wire logic                   CORE_WR,
  input wire logic                   CORE_RD,
  input wire logic                   TDO_OE,
  input wire logic [`JDSC_BSR_W-1:0] PIN_OE,
  input wire logic                   SHARED_IO_WR,
  input wire logic                   CORE_RESULT_VALID,
  input wire logic                   CORE_INJECT_STB,
  input wire logic                   DEBUG_ACTIVE,
  input wire logic                   DEBUG_FUSE_PROG_OK,
  input wire logic                   DEVICE_RESET
);
  wire logic locked = LOCK_BIT_ONE | LOCK_BIT_TWO;  // either lock bit set
  logic      erased_reg;                             // erase seen while still locked
  // an erase lifts the refusal only until the locks are cleared
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) erased_reg <= 1'b0;
    else if (CHIP_ERASE_DONE) erased_reg <= 1'b1;
    else if (!locked) erased_reg <= 1'b0;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  property p_rd_answer; CORE_RD |=> CORE_RESULT_VALID; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("core read not answered");
  property p_dbg_lock; locked [*3] |-> !DEBUG_ACTIVE; endproperty
  a_dbg_lock: assert property (p_dbg_lock) else $error("debug active while locked");
  property p_port_off; (!PORT_ENABLE_FUSE || PORT_DISABLE_BIT) [*3] |-> !TDO_OE; endproperty
  a_port_off: assert property (p_port_off) else $error("scan out driven while off");
  property p_reset_hiz; DEVICE_RESET && $past(DEVICE_RESET) |-> PIN_OE == '0; endproperty
  a_reset_hiz: assert property (p_reset_hiz) else $error("pins driven in reset");
  property p_pin_reset; !RESET_PIN_N [*4] |-> DEVICE_RESET; endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin ignored");
  property p_fuse_refuse; (locked && !erased_reg) [*2] |-> !DEBUG_FUSE_PROG_OK; endproperty
  a_fuse_refuse: assert property (p_fuse_refuse) else $error("fuse allowed while locked");
  property p_shared_wr; CORE_WR && !DEBUG_ENABLE_FUSE |=> SHARED_IO_WR; endproperty
  a_shared_wr: assert property (p_shared_wr) else $error("write missed shared place");
  property p_inject_pulse; CORE_INJECT_STB |=> !CORE_INJECT_STB; endproperty
  a_inject_pulse: assert property (p_inject_pulse) else $error("inject strobe too long");
  // main scenarios reached
  c_inject: cover property (CORE_INJECT_STB);
  c_reset: cover property (DEVICE_RESET ##1 !DEVICE_RESET);
  c_shared: cover property (SHARED_IO_WR);
endmodule : jdsc_assertions
bind jdsc_top jdsc_assertions u_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
  .RESET_PIN_N(RESET_PIN_N), .PORT_ENABLE_FUSE(PORT_ENABLE_FUSE),
  .DEBUG_ENABLE_FUSE(DEBUG_ENABLE_FUSE), .LOCK_BIT_ONE(LOCK_BIT_ONE),
  .LOCK_BIT_TWO(LOCK_BIT_TWO), .PORT_DISABLE_BIT(PORT_DISABLE_BIT),
  .CHIP_ERASE_DONE(CHIP_ERASE_DONE), .CORE_WR(CORE_WR), .CORE_RD(CORE_RD),
  .TDO_OE(TDO_OE), .PIN_OE(PIN_OE), .SHARED_IO_WR(SHARED_IO_WR),
  .CORE_RESULT_VALID(CORE_RESULT_VALID), .CORE_INJECT_STB(CORE_INJECT_STB),
  .DEBUG_ACTIVE(DEBUG_ACTIVE), .DEBUG_FUSE_PROG_OK(DEBUG_FUSE_PROG_OK),
  .DEVICE_RESET(DEVICE_RESET));
`default_nettype wire

// ### jdsc_tap_model.sv
// external test controller: drives tck, tms and tdi, samples tdo
// assumes a free 4 ns clock; scan clock is 160 ns and stands still between accesses
`timescale 1ns/1ps
`default_nettype none
module jdsc_tap_model (
  input  wire logic clk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  localparam int HALF = 20;  // half scan period in system cycles
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one scan bit; only the four pins are used for any access
  // low phase counts the edge that starts the bit, so the period is 2*HALF
  task automatic tick(input logic m, input logic d, output logic o);
    @(posedge clk);
    tms <= m;
    tdi <= d;
    repeat (HALF - 1) @(posedge clk);
    o = tdo;
    tck <= 1'b1;
    repeat (HALF) @(posedge clk);
    tck <= 1'b0;
    tdi <= 1'b1;  // released input sits at its pull-up
  endtask : tick
  // from idle through capture, n shifts lsb first, update, back to idle
  task automatic shift(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
    logic o;
    dout = '0;
    tick(1'b1, 1'b1, o);
    if (ir) tick(1'b1, 1'b1, o);
    tick(1'b0, 1'b1, o);
    tick(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'b1, 1'b1, o);  // enters update; the next rise ends a channel read, clearing dirty
    tick(1'b0, 1'b1, o);
  endtask : shift
endmodule : jdsc_tap_model
`default_nettype wire

// ### tb_jdsc_top.sv
// self-checking bench of the test-port block
// assumes jdsc_top, the tap model and the checker bind are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "jdsc_defs.svh"
module tb_jdsc_top;
  logic SYS_CLK = 1'b0, SYS_RST = 1'b1, RESET_PIN_N = 1'b1;
  logic PORT_ENABLE_FUSE = 1'b1, DEBUG_ENABLE_FUSE = 1'b1, PORT_DISABLE_BIT = 1'b0;
  logic LOCK_BIT_ONE = 1'b0, LOCK_BIT_TWO = 1'b0, CHIP_ERASE_DONE = 1'b0;
  logic DEBUG_FUSE_PROG_REQ = 1'b0, CORE_WR = 1'b0, CORE_RD = 1'b0;
  logic CORE_PC_CHANGE = 1'b0, CORE_STEP_DONE = 1'b0, CORE_DVALID = 1'b0;
  logic [7:0] PIN_IN = 8'hc3, CORE_PIN_OUT = 8'h0f, CORE_PIN_OE = 8'hff;
  logic [7:0] CORE_WDATA = 8'h00, SHARED_IO_RDATA = 8'h6c;
  logic [15:0] CORE_PC = 16'hfff0, CORE_DADDR = 16'h0000;
  logic TCK, TMS, TDI, TDO, TDO_OE, CORE_RESULT_VALID, SHARED_IO_WR, CORE_BREAK;
  logic CORE_INJECT_STB, DEBUG_ACTIVE, DEBUG_FUSE_PROG_OK, DEVICE_RESET;
  logic [7:0] PIN_OUT, PIN_OE, CORE_RDATA, rd;
  logic [15:0] CORE_INJECT, inj;
  logic [31:0] v;
  logic shw = 1'b0, oe_seen = 1'b0;  // sticky pulse catchers
  int fails = 0, checked = 0;
  jdsc_top dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .TCK(TCK), .TMS(TMS), .TDI(TDI),
    .TDO(TDO), .TDO_OE(TDO_OE), .RESET_PIN_N(RESET_PIN_N),
    .PORT_ENABLE_FUSE(PORT_ENABLE_FUSE), .DEBUG_ENABLE_FUSE(DEBUG_ENABLE_FUSE),
    .LOCK_BIT_ONE(LOCK_BIT_ONE), .LOCK_BIT_TWO(LOCK_BIT_TWO),
    .PORT_DISABLE_BIT(PORT_DISABLE_BIT), .CHIP_ERASE_DONE(CHIP_ERASE_DONE),
    .DEBUG_FUSE_PROG_REQ(DEBUG_FUSE_PROG_REQ), .PIN_IN(PIN_IN),
    .CORE_PIN_OUT(CORE_PIN_OUT), .CORE_PIN_OE(CORE_PIN_OE), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE), .CORE_WR(CORE_WR), .CORE_RD(CORE_RD), .CORE_WDATA(CORE_WDATA),
    .CORE_RDATA(CORE_RDATA), .CORE_RESULT_VALID(CORE_RESULT_VALID),
    .SHARED_IO_RDATA(SHARED_IO_RDATA), .SHARED_IO_WR(SHARED_IO_WR),
    .CORE_PC_CHANGE(CORE_PC_CHANGE), .CORE_STEP_DONE(CORE_STEP_DONE), .CORE_PC(CORE_PC),
    .CORE_DADDR(CORE_DADDR), .CORE_DVALID(CORE_DVALID), .CORE_BREAK(CORE_BREAK),
    .CORE_INJECT(CORE_INJECT), .CORE_INJECT_STB(CORE_INJECT_STB),
    .DEBUG_ACTIVE(DEBUG_ACTIVE), .DEBUG_FUSE_PROG_OK(DEBUG_FUSE_PROG_OK),
    .DEVICE_RESET(DEVICE_RESET));
  jdsc_tap_model tap (.clk(SYS_CLK), .tck(TCK), .tms(TMS), .tdi(TDI), .tdo(TDO));
  always #2 SYS_CLK = ~SYS_CLK;
  // one-cycle outputs are caught here so tests can look at them later
  always @(posedge SYS_CLK) begin
    if (CORE_INJECT_STB === 1'b1) inj <= CORE_INJECT;
    if (SHARED_IO_WR === 1'b1) shw <= 1'b1;
    if (TDO_OE === 1'b1) oe_seen <= 1'b1;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wait_clk(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask : wait_clk
  task automatic core_wr(input logic [7:0] d);
    @(posedge SYS_CLK);
    CORE_WR <= 1'b1;
    CORE_WDATA <= d;
    @(posedge SYS_CLK);
    CORE_WR <= 1'b0;
    wait_clk(2);
  endtask : core_wr
  // answer lands one cycle after the read strobe is taken
  task automatic core_rd(output logic [7:0] d);
    @(posedge SYS_CLK);
    CORE_RD <= 1'b1;
    @(posedge SYS_CLK);
    CORE_RD <= 1'b0;
    #1;
    d = CORE_RDATA;
    check("read valid", CORE_RESULT_VALID, 1'b1);
  endtask : core_rd
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // watchdog: the whole sequence needs about 12000 cycles
  initial begin
    repeat (60000) @(posedge SYS_CLK);
    fails++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    wait_clk(6);
    tap.tick(1'b0, 1'b1, v[0]);
    tap.shift(1'b0, 32, 32'h0, v);
    check("idcode", v, `JDSC_ID_CODE);
    tap.shift(1'b1, 4, `JDSC_IR_BYPASS, v);
    check("ir capture", v[3:0], `JDSC_IR_CAPTURE);
    tap.shift(1'b0, 3, 32'h3, v);
    check("bypass", v[2:0], 3'h6);
    done("scan path");
    tap.shift(1'b1, 4, `JDSC_IR_DBG_D, v);
    tap.shift(1'b0, 16, 32'h1, v);
    check("debug on", DEBUG_ACTIVE, 1'b1);
    core_wr(8'h35);
    core_rd(rd);
    check("core read dirty", rd, 8'hb5);
    tap.shift(1'b1, 4, `JDSC_IR_DBG_B, v);
    tap.shift(1'b0, 16, 32'h0, v);
    check("channel scan", v[15:0], 16'h0035);
    core_rd(rd);
    check("core read clean", rd, 8'h35);
    tap.shift(1'b1, 4, `JDSC_IR_DBG_A, v);
    tap.shift(1'b0, 16, 32'h1234, v);
    check("inject", inj, 16'h1234);
    tap.shift(1'b1, 4, `JDSC_IR_DBG_C, v);
    tap.shift(1'b0, 16, 32'h8000 | `JDSC_BPCFG_4P, v);
    tap.shift(1'b0, 16, 32'h0100, v);
    CORE_PC <= 16'h0100;
    wait_clk(10);
    check("break", CORE_BREAK, 1'b1);
    // move off the address, then arm the break on a change of flow
    @(posedge SYS_CLK);
    CORE_PC <= 16'hfff0;
    tap.shift(1'b1, 4, `JDSC_IR_DBG_D, v);
    tap.shift(1'b0, 16, 32'h3, v);
    check("break cleared", CORE_BREAK, 1'b0);
    CORE_PC_CHANGE <= 1'b1;
    wait_clk(3);
    check("flow break", CORE_BREAK, 1'b1);
    @(posedge SYS_CLK);
    CORE_PC_CHANGE <= 1'b0;
    done("debug");
    @(posedge SYS_CLK);
    DEBUG_FUSE_PROG_REQ <= 1'b1;
    LOCK_BIT_ONE <= 1'b1;
    wait_clk(4);
    check("locked debug", DEBUG_ACTIVE, 1'b0);
    check("fuse refused", DEBUG_FUSE_PROG_OK, 1'b0);
    @(posedge SYS_CLK);
    CHIP_ERASE_DONE <= 1'b1;
    @(posedge SYS_CLK);
    CHIP_ERASE_DONE <= 1'b0;
    LOCK_BIT_TWO <= 1'b1;
    LOCK_BIT_ONE <= 1'b0;
    wait_clk(4);
    check("fuse after erase", DEBUG_FUSE_PROG_OK, 1'b1);
    check("second lock", DEBUG_ACTIVE, 1'b0);
    @(posedge SYS_CLK);
    LOCK_BIT_TWO <= 1'b0;
    DEBUG_ENABLE_FUSE <= 1'b0;
    core_wr(8'h11);
    check("shared write", shw, 1'b1);
    core_rd(rd);
    check("shared read", rd, 8'h6c);
    done("locks");
    tap.shift(1'b1, 4, `JDSC_IR_SAMPLE, v);
    tap.shift(1'b0, 8, 32'h5a, v);
    check("sample pins", v[7:0], PIN_IN);
    check("core drive kept", PIN_OUT, CORE_PIN_OUT);
    tap.shift(1'b1, 4, `JDSC_IR_EXTEST, v);
    check("extest drive", PIN_OUT, 8'h5a);
    tap.shift(1'b1, 4, `JDSC_IR_SCANRST, v);
    tap.shift(1'b0, 1, 32'h1, v);
    check("scan reset", DEVICE_RESET, 1'b1);
    check("reset high z", PIN_OE, 8'h00);
    tap.shift(1'b0, 1, 32'h0, v);
    check("scan reset off", DEVICE_RESET, 1'b0);
    @(posedge SYS_CLK);
    RESET_PIN_N <= 1'b0;
    wait_clk(6);
    check("pin reset", DEVICE_RESET, 1'b1);
    check("scan out driven", oe_seen, 1'b1);
    @(posedge SYS_CLK);
    RESET_PIN_N <= 1'b1;
    PORT_DISABLE_BIT <= 1'b1;
    oe_seen <= 1'b0;
    tap.shift(1'b1, 4, `JDSC_IR_BYPASS, v);
    check("port disabled", oe_seen, 1'b0);
    done("boundary and reset");
    finish_test();
  end
endmodule : tb_jdsc_top
`default_nettype wire
